// ### zts_pkg.sv
/*
 * zts_pkg: constants, register offsets, field positions and carrier types
 * for the zone tracking status input image.
 * assumes: a single 250 MHz clock domain in the module that imports it.
 */
`default_nettype none

package zts_pkg;

    localparam int unsigned ZTS_WORD_W = 16;
    localparam int unsigned ZTS_ADDR_W = 8;

    typedef logic [ZTS_WORD_W-1:0] zts_word_t;
    typedef logic [ZTS_ADDR_W-1:0] zts_addr_t;

    // word offsets in the module address space
    localparam zts_addr_t ZTS_OFF_LINE_STOP  = 8'h13;
    localparam zts_addr_t ZTS_OFF_SENSOR     = 8'h23;
    localparam zts_addr_t ZTS_OFF_RESET_PROT = 8'h24;
    localparam zts_addr_t ZTS_OFF_UP_REL     = 8'h69;
    localparam zts_addr_t ZTS_OFF_UP_TRK1    = 8'h77;
    localparam zts_addr_t ZTS_OFF_UP_TRK2    = 8'h78;
    localparam zts_addr_t ZTS_OFF_REV_TRK1   = 8'h79;
    localparam zts_addr_t ZTS_OFF_REV_TRK2   = 8'h7a;
    localparam zts_addr_t ZTS_OFF_DN_REL     = 8'hb9;
    localparam zts_addr_t ZTS_OFF_DN_TRK1    = 8'hc7;
    localparam zts_addr_t ZTS_OFF_DN_TRK2    = 8'hc8;
    localparam zts_addr_t ZTS_OFF_FWD_TRK1   = 8'hc9;
    localparam zts_addr_t ZTS_OFF_FWD_TRK2   = 8'hca;

    // sensor port word: port i sits at bit i * stride
    localparam int unsigned ZTS_SP_PORTS     = 4;
    localparam int unsigned ZTS_SP_STRIDE    = 2;
    localparam int unsigned ZTS_SP_LEFT_AUX  = 0;
    localparam int unsigned ZTS_SP_RIGHT_AUX = 2;
    localparam int unsigned ZTS_SP_LEFT_SEN  = 4;
    localparam int unsigned ZTS_SP_RIGHT_SEN = 6;
    localparam int unsigned ZTS_SP_HEART     = 15;

    // line stop word
    localparam int unsigned ZTS_LS_GROUP     = 5;
    localparam int unsigned ZTS_LS_COMM      = 6;
    localparam int unsigned ZTS_LS_PLC_LOST  = 7;
    localparam int unsigned ZTS_LS_PLC_CMD   = 10;
    localparam zts_word_t   ZTS_LS_MASK      = 16'h04e0;
    localparam zts_word_t   ZTS_SP_MASK      = 16'h8055;

    localparam zts_word_t   ZTS_WORD_RST     = 16'h0000;

    // heartbeat timing
    localparam int unsigned ZTS_CLK_HZ       = 250_000_000;
    localparam int unsigned ZTS_HB_HALF_SEC  = 2;
    localparam int unsigned ZTS_HB_HALF_CYC  = ZTS_HB_HALF_SEC * ZTS_CLK_HZ;
    localparam int unsigned ZTS_HB_CNT_W     = 32;

    typedef struct packed {
        zts_word_t word1;
        zts_word_t word2;
    } zts_trk_t;

    // bit 0 left aux, 1 right aux, 2 left sensor, 3 right sensor
    typedef logic [ZTS_SP_PORTS-1:0] zts_ports_t;

    typedef struct packed {
        logic plcStopCmd;
        logic plcLost;
        logic commLost;
        logic groupStop;
    } zts_stop_t;

    typedef struct packed {
        logic      en;
        zts_addr_t addr;
    } zts_rd_t;

    typedef struct packed {
        logic      en;
        zts_addr_t addr;
        zts_word_t data;
    } zts_wr_t;

    typedef enum logic [1:0] {
        ZTS_HB_HIGH = 2'b01,
        ZTS_HB_LOW  = 2'b10
    } zts_hb_t;

endpackage

`default_nettype wire

// ### zts_plc_model.sv
/*
 * zts_plc_model: external controller model, issues word reads and writes
 * and owns the release output registers.
 * assumes: the image block answers one mclk after each request edge.
 */
`timescale 1ns/1ps
`default_nettype none

module zts_plc_model
    import zts_pkg::*;
(
    input  wire logic      mclk,
    input  wire zts_word_t rdData,
    input  wire logic      rdValid,
    input  wire logic      rdMiss,
    input  wire logic      wrAck,
    output var  zts_rd_t   rdReq,
    output var  zts_wr_t   wrReq,
    output var  zts_word_t relUpCount,
    output var  zts_word_t relDnCount
);
    zts_word_t burst [32];

    initial begin
        rdReq = '0;
        wrReq = '0;
        relUpCount = '0;
        relDnCount = '0;
    end

    // one read, address held through the taking edge
    task automatic rd(input zts_addr_t a, output zts_word_t d,
                      output logic v, output logic m);
        @(posedge mclk);
        rdReq <= '{en: 1'b1, addr: a};
        @(posedge mclk);
        rdReq <= '{en: 1'b0, addr: a};
        #1;
        d = rdData;
        v = rdValid;
        m = rdMiss;
    endtask

    task automatic wr(input zts_addr_t a, input zts_word_t w,
                      output logic ack);
        @(posedge mclk);
        wrReq <= '{en: 1'b1, addr: a, data: w};
        @(posedge mclk);
        wrReq <= '{en: 1'b0, addr: a, data: w};
        #1;
        ack = wrAck;
    endtask

    // back-to-back reads, one per cycle
    task automatic rdRun(input zts_addr_t a, input int n);
        @(posedge mclk);
        rdReq <= '{en: 1'b1, addr: a};
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            if (i == n - 1) begin
                rdReq <= '{en: 1'b0, addr: a};
            end
            #1;
            burst[i] = rdData;
        end
    endtask

    // confirm the mirror before loading a new release value
    task automatic setRelease(input logic up, input zts_word_t val,
                              output zts_word_t seen);
        logic v;
        logic m;
        rd(up ? ZTS_OFF_UP_REL : ZTS_OFF_DN_REL, seen, v, m);
        @(posedge mclk);
        if (up) begin
            relUpCount <= val;
        end else begin
            relDnCount <= val;
        end
    endtask
endmodule

`default_nettype wire

// ### zts_status_inputs.sv
/*
 * zts_status_inputs: read-only input image of a conveyor zone controller,
 * tracking words, release mirrors, hand-off tracking, sensor port bits
 * with heartbeat, and line stop cause flags, behind a word read port.
 * assumes: zone logic, auto-configuration and release output registers sit
 * outside and present levels and pulses synchronous to mclk.
 */
// How it works
// - an upstream carton accumulated and stopped shows its two tracking words
// - a downstream carton accumulated and stopped shows its two tracking words
// - each zone's release output value is copied into a readable mirror
// - a forward discharge to unmanaged conveyor loads the forward words
// - a reverse discharge to unmanaged conveyor loads the reverse words
// - left aux input sits at bit 0 and right aux input at bit 2
// - left sensor at bit 4, right sensor at bit 6, other bits reserved
// - bit 15 is a heartbeat, two seconds high then two seconds low
// - a sensor bit is 1 when blocked and 0 when clear, whatever polarity
// - the polarity applied comes from the first auto-configuration result
// - line stop bit 5 is a group stop, bit 6 a lost communication stop
// - line stop bit 7 is a lost controller link, bit 10 a commanded stop
// - line stop bits 0 to 4, 8, 9 and 11 to 15 are reserved
// - sensor and line stop words cannot be changed by external writes
// - the word after the sensor word carries only reset protection data
`timescale 1ns/1ps
`default_nettype none

module zts_status_inputs
    import zts_pkg::*;
#(
    parameter int unsigned HB_HALF_CYCLES = ZTS_HB_HALF_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire zts_rd_t    rdReq,
    output var  zts_word_t  rdData,
    output var  logic       rdValid,
    output var  logic       rdMiss,
    input  wire zts_wr_t    wrReq,
    output var  logic       wrAck,
    input  wire logic       upAccum,
    input  wire zts_trk_t   upTrk,
    input  wire logic       dnAccum,
    input  wire zts_trk_t   dnTrk,
    input  wire zts_word_t  relUpCount,
    input  wire zts_word_t  relDnCount,
    input  wire logic       discharge,
    input  wire logic       unmanagedDis,
    input  wire logic       reverseDir,
    input  wire zts_trk_t   dischargeTrk,
    input  wire zts_ports_t sensorRaw,
    input  wire logic       autoCfgDone,
    input  wire zts_ports_t autoCfgInvert,
    input  wire zts_stop_t  stopCause,
    input  wire zts_word_t  resetProtWord
);

    zts_trk_t                upTrk_reg;
    zts_trk_t                dnTrk_reg;
    zts_trk_t                fwdTrk_reg;
    zts_trk_t                revTrk_reg;
    zts_word_t               relUp_reg;
    zts_word_t               relDn_reg;
    zts_word_t               resetProt_reg;
    zts_word_t               sensorWord_reg;
    zts_word_t               lineStop_reg;
    zts_ports_t              invert_reg;
    logic                    cfgSeen_reg;
    zts_hb_t                 hbState_reg;
    zts_hb_t                 hbState_next;
    logic [ZTS_HB_CNT_W-1:0] hbCount_reg;
    logic [ZTS_HB_CNT_W-1:0] hbCount_next;
    zts_word_t               rdData_reg;
    logic                    rdValid_reg;
    logic                    rdMiss_reg;
    logic                    wrAck_reg;

    // zone and hand-off capture
    wire logic     fwdLoad = discharge && unmanagedDis && !reverseDir;
    wire logic     revLoad = discharge && unmanagedDis && reverseDir;
    wire zts_trk_t upTrkNext = upAccum ? upTrk : '0;
    wire zts_trk_t dnTrkNext = dnAccum ? dnTrk : '0;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            upTrk_reg  <= '0;
            dnTrk_reg  <= '0;
            fwdTrk_reg <= '0;
            revTrk_reg <= '0;
        end else begin
            upTrk_reg <= upTrkNext;
            dnTrk_reg <= dnTrkNext;
            if (fwdLoad) begin
                fwdTrk_reg <= dischargeTrk;
            end
            if (revLoad) begin
                revTrk_reg <= dischargeTrk;
            end
        end
    end

    // mirrors follow the release registers one cycle late
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            relUp_reg     <= ZTS_WORD_RST;
            relDn_reg     <= ZTS_WORD_RST;
            resetProt_reg <= ZTS_WORD_RST;
        end else begin
            relUp_reg     <= relUpCount;
            relDn_reg     <= relDnCount;
            resetProt_reg <= resetProtWord;
        end
    end

    // polarity taken once; later configuration pulses are ignored
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            invert_reg  <= '0;
            cfgSeen_reg <= 1'b0;
        end else if (autoCfgDone && !cfgSeen_reg) begin
            invert_reg  <= autoCfgInvert;
            cfgSeen_reg <= 1'b1;
        end
    end

    // heartbeat, one phase per half period
    wire logic hbWrap = hbCount_reg == ZTS_HB_CNT_W'(HB_HALF_CYCLES - 1);

    always_comb begin
        hbCount_next = hbCount_reg + ZTS_HB_CNT_W'(1);
        hbState_next = hbState_reg;
        if (hbWrap) begin
            hbCount_next = '0;
            unique case (hbState_reg)
                ZTS_HB_HIGH: hbState_next = ZTS_HB_LOW;
                ZTS_HB_LOW:  hbState_next = ZTS_HB_HIGH;
                default:     hbState_next = ZTS_HB_HIGH;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hbCount_reg <= '0;
            hbState_reg <= ZTS_HB_HIGH;
        end else begin
            hbCount_reg <= hbCount_next;
            hbState_reg <= hbState_next;
        end
    end

    // sensor word, unused bits stay zero
    wire zts_word_t sensorNext;

    assign sensorNext[ZTS_SP_HEART] = hbState_reg == ZTS_HB_HIGH;

    genvar gi;
    generate
        for (gi = 0; gi < ZTS_SP_PORTS; gi++) begin : g_port
            assign sensorNext[gi*ZTS_SP_STRIDE] =
                sensorRaw[gi] ^ invert_reg[gi];
            assign sensorNext[gi*ZTS_SP_STRIDE+1] = 1'b0;
        end
    endgenerate

    assign sensorNext[ZTS_SP_HEART-1:ZTS_SP_PORTS*ZTS_SP_STRIDE] = '0;

    // line stop word, reserved bits tied low
    wire zts_word_t lineStopNext =
        ({15'h0000, stopCause.groupStop}  << ZTS_LS_GROUP)    |
        ({15'h0000, stopCause.commLost}   << ZTS_LS_COMM)     |
        ({15'h0000, stopCause.plcLost}    << ZTS_LS_PLC_LOST) |
        ({15'h0000, stopCause.plcStopCmd} << ZTS_LS_PLC_CMD);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sensorWord_reg <= ZTS_WORD_RST;
            lineStop_reg   <= ZTS_WORD_RST;
        end else begin
            sensorWord_reg <= sensorNext;
            lineStop_reg   <= lineStopNext & ZTS_LS_MASK;
        end
    end

    // read decode
    wire logic hitLs   = rdReq.addr == ZTS_OFF_LINE_STOP;
    wire logic hitSp   = rdReq.addr == ZTS_OFF_SENSOR;
    wire logic hitRp   = rdReq.addr == ZTS_OFF_RESET_PROT;
    wire logic hitUr   = rdReq.addr == ZTS_OFF_UP_REL;
    wire logic hitU1   = rdReq.addr == ZTS_OFF_UP_TRK1;
    wire logic hitU2   = rdReq.addr == ZTS_OFF_UP_TRK2;
    wire logic hitR1   = rdReq.addr == ZTS_OFF_REV_TRK1;
    wire logic hitR2   = rdReq.addr == ZTS_OFF_REV_TRK2;
    wire logic hitDr   = rdReq.addr == ZTS_OFF_DN_REL;
    wire logic hitD1   = rdReq.addr == ZTS_OFF_DN_TRK1;
    wire logic hitD2   = rdReq.addr == ZTS_OFF_DN_TRK2;
    wire logic hitF1   = rdReq.addr == ZTS_OFF_FWD_TRK1;
    wire logic hitF2   = rdReq.addr == ZTS_OFF_FWD_TRK2;
    wire logic rdHit   = hitLs | hitSp | hitRp | hitUr | hitU1 | hitU2 |
                         hitR1 | hitR2 | hitDr | hitD1 | hitD2 | hitF1 |
                         hitF2;

    wire zts_word_t rdSel =
        ({ZTS_WORD_W{hitLs}} & lineStop_reg)     |
        ({ZTS_WORD_W{hitSp}} & sensorWord_reg)   |
        ({ZTS_WORD_W{hitRp}} & resetProt_reg)    |
        ({ZTS_WORD_W{hitUr}} & relUp_reg)        |
        ({ZTS_WORD_W{hitU1}} & upTrk_reg.word1)  |
        ({ZTS_WORD_W{hitU2}} & upTrk_reg.word2)  |
        ({ZTS_WORD_W{hitR1}} & revTrk_reg.word1) |
        ({ZTS_WORD_W{hitR2}} & revTrk_reg.word2) |
        ({ZTS_WORD_W{hitDr}} & relDn_reg)        |
        ({ZTS_WORD_W{hitD1}} & dnTrk_reg.word1)  |
        ({ZTS_WORD_W{hitD2}} & dnTrk_reg.word2)  |
        ({ZTS_WORD_W{hitF1}} & fwdTrk_reg.word1) |
        ({ZTS_WORD_W{hitF2}} & fwdTrk_reg.word2);

    // writes are acknowledged but land nowhere: the image is input only
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_reg  <= ZTS_WORD_RST;
            rdValid_reg <= 1'b0;
            rdMiss_reg  <= 1'b0;
            wrAck_reg   <= 1'b0;
        end else begin
            rdData_reg  <= rdReq.en ? rdSel : ZTS_WORD_RST;
            rdValid_reg <= rdReq.en;
            rdMiss_reg  <= rdReq.en && !rdHit;
            wrAck_reg   <= wrReq.en;
        end
    end

    assign rdData  = rdData_reg;
    assign rdValid = rdValid_reg;
    assign rdMiss  = rdMiss_reg;
    assign wrAck   = wrAck_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_up_track_show: assert property (
        upAccum |=> upTrk_reg == $past(upTrk)
    ) else $error("upstream tracking not shown");

    a_dn_track_clear: assert property (
        dnAccum ##1 !dnAccum |=> dnTrk_reg == '0
    ) else $error("downstream tracking not cleared");

    a_dn_track_show: assert property (
        dnAccum |=> dnTrk_reg == $past(dnTrk)
    ) else $error("downstream tracking not shown");

    a_rel_mirror: assert property (
        ##1 (relUp_reg == $past(relUpCount) && relDn_reg == $past(relDnCount))
    ) else $error("release mirror stale");

    a_fwd_load: assert property (
        fwdLoad |=> fwdTrk_reg == $past(dischargeTrk)
                    && $stable(revTrk_reg)
    ) else $error("forward hand-off not loaded");

    a_rev_load: assert property (
        revLoad |=> revTrk_reg == $past(dischargeTrk)
                    && $stable(fwdTrk_reg)
    ) else $error("reverse hand-off not loaded");

    a_aux_bits: assert property (
        ##1 (sensorWord_reg[ZTS_SP_LEFT_AUX] ==
             $past(sensorRaw[0] ^ invert_reg[0])
          && sensorWord_reg[ZTS_SP_RIGHT_AUX] ==
             $past(sensorRaw[1] ^ invert_reg[1]))
    ) else $error("aux bit wrong");

    a_sensor_bits: assert property (
        ##1 (sensorWord_reg[ZTS_SP_LEFT_SEN] ==
             $past(sensorRaw[2] ^ invert_reg[2])
          && sensorWord_reg[ZTS_SP_RIGHT_SEN] ==
             $past(sensorRaw[3] ^ invert_reg[3]))
    ) else $error("sensor bit wrong");

    a_hb_toggle: assert property (
        $changed(hbState_reg) |-> $past(hbCount_reg) ==
            ZTS_HB_CNT_W'(HB_HALF_CYCLES - 1) && hbCount_reg == '0
    ) else $error("heartbeat toggled off period");

    a_polarity_blocked: assert property (
        cfgSeen_reg && sensorRaw[2] != invert_reg[2] && $stable(sensorRaw)
        |=> sensorWord_reg[ZTS_SP_LEFT_SEN]
    ) else $error("blocked sensor not read as one");

    a_cfg_once: assert property (
        cfgSeen_reg |=> $stable(invert_reg)
    ) else $error("polarity changed after configuration");

    a_stop_bits: assert property (
        ##1 (lineStop_reg[ZTS_LS_GROUP] == $past(stopCause.groupStop)
          && lineStop_reg[ZTS_LS_COMM] == $past(stopCause.commLost))
    ) else $error("group or comm stop bit wrong");

    a_plc_bits: assert property (
        ##1 (lineStop_reg[ZTS_LS_PLC_LOST] == $past(stopCause.plcLost)
          && lineStop_reg[ZTS_LS_PLC_CMD] == $past(stopCause.plcStopCmd))
    ) else $error("controller stop bit wrong");

    a_rsvd_zero: assert property (
        (lineStop_reg & ~ZTS_LS_MASK) == '0
        && (sensorWord_reg & ~ZTS_SP_MASK) == '0
    ) else $error("reserved bit set");

    a_read_stop: assert property (
        rdReq.en && hitLs |=> rdValid_reg
            && rdData_reg == $past(lineStop_reg)
    ) else $error("line stop read wrong");

    a_read_prot: assert property (
        rdReq.en && hitRp |=> rdData_reg == $past(resetProtWord, 2)
    ) else $error("reset protection word wrong");

    a_miss_zero: assert property (
        rdReq.en && !rdHit |=> rdMiss_reg && rdData_reg == '0
    ) else $error("unmapped read not zero");

    a_up_track_clear: assert property (
        !upAccum |=> upTrk_reg == '0
    ) else $error("upstream tracking not cleared");

    a_write_ack: assert property (
        ##1 (wrAck_reg == $past(wrReq.en))
    ) else $error("write acknowledge wrong");

    a_hb_count_range: assert property (
        hbCount_reg < ZTS_HB_CNT_W'(HB_HALF_CYCLES)
    ) else $error("heartbeat counter out of range");

    c_fwd_handoff: cover property (fwdLoad ##1 rdReq.en && hitF1);
    c_rev_handoff: cover property (revLoad ##1 rdReq.en && hitR2);
    c_hb_toggle:   cover property ($changed(hbState_reg));
    c_write_try:   cover property (wrReq.en && wrReq.addr == ZTS_OFF_SENSOR);

endmodule

`default_nettype wire

// ### zts_status_inputs_test.sv
/*
 * zts_status_inputs_test: self-checking bench for the status input image.
 * assumes: heartbeat half period shortened to 8 cycles, plc model drives
 * the read and write ports and the release registers.
 */
`timescale 1ns/1ps
`default_nettype none

module zts_status_inputs_test
    import zts_pkg::*;
;
    logic       mclk;
    logic       rst_b;
    zts_rd_t    rdReq;
    zts_wr_t    wrReq;
    zts_word_t  rdData;
    logic       rdValid;
    logic       rdMiss;
    logic       wrAck;
    logic       upAccum;
    logic       dnAccum;
    zts_trk_t   upTrk;
    zts_trk_t   dnTrk;
    zts_word_t  relUpCount;
    zts_word_t  relDnCount;
    logic       discharge;
    logic       unmanagedDis;
    logic       reverseDir;
    zts_trk_t   dischargeTrk;
    zts_ports_t sensorRaw;
    logic       autoCfgDone;
    zts_ports_t autoCfgInvert;
    zts_stop_t  stopCause;
    zts_word_t  resetProtWord;
    int         failCount;
    int         checks;

    zts_status_inputs #(.HB_HALF_CYCLES(8)) DUT (
        .mclk(mclk), .rst_b(rst_b), .rdReq(rdReq), .rdData(rdData),
        .rdValid(rdValid), .rdMiss(rdMiss), .wrReq(wrReq), .wrAck(wrAck),
        .upAccum(upAccum), .upTrk(upTrk), .dnAccum(dnAccum), .dnTrk(dnTrk),
        .relUpCount(relUpCount), .relDnCount(relDnCount),
        .discharge(discharge), .unmanagedDis(unmanagedDis),
        .reverseDir(reverseDir), .dischargeTrk(dischargeTrk),
        .sensorRaw(sensorRaw), .autoCfgDone(autoCfgDone),
        .autoCfgInvert(autoCfgInvert), .stopCause(stopCause),
        .resetProtWord(resetProtWord));

    zts_plc_model plc (
        .mclk(mclk), .rdData(rdData), .rdValid(rdValid), .rdMiss(rdMiss),
        .wrAck(wrAck), .rdReq(rdReq), .wrReq(wrReq),
        .relUpCount(relUpCount), .relDnCount(relDnCount));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chkWord(input zts_word_t got, input zts_word_t exp);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkFlag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdChk(input zts_addr_t a, input zts_word_t e);
        zts_word_t d;
        logic v;
        logic m;
        plc.rd(a, d, v, m);
        chkWord(d, e);
        chkFlag(v, 1'b1);
        chkFlag(m, 1'b0);
    endtask

    // sensor word without the heartbeat bit
    task automatic sensChk(input zts_word_t e);
        zts_word_t d;
        logic v;
        logic m;
        plc.rd(ZTS_OFF_SENSOR, d, v, m);
        chkWord(d & 16'h7fff, e);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic testCarton;
        zts_trk_t t;
        t = '{word1: 16'h1234, word2: 16'hbeef};
        @(posedge mclk);
        upAccum <= 1'b1;
        upTrk <= t;
        dnAccum <= 1'b1;
        dnTrk <= ~t;
        step(2);
        rdChk(ZTS_OFF_UP_TRK1, t.word1);
        rdChk(ZTS_OFF_UP_TRK2, t.word2);
        rdChk(ZTS_OFF_DN_TRK1, ~t.word1);
        rdChk(ZTS_OFF_DN_TRK2, ~t.word2);
        @(posedge mclk);
        upAccum <= 1'b0;
        dnAccum <= 1'b0;
        step(2);
        rdChk(ZTS_OFF_UP_TRK1, 16'h0000);
        rdChk(ZTS_OFF_DN_TRK2, 16'h0000);
        $display("carton tracking test done");
    endtask

    task automatic testRelease;
        zts_word_t seen;
        plc.setRelease(1'b1, 16'h0007, seen);
        chkWord(seen, 16'h0000);
        step(2);
        rdChk(ZTS_OFF_UP_REL, 16'h0007);
        plc.setRelease(1'b1, 16'h0008, seen);
        chkWord(seen, 16'h0007);
        plc.setRelease(1'b0, 16'h00a0, seen);
        chkWord(seen, 16'h0000);
        step(2);
        rdChk(ZTS_OFF_DN_REL, 16'h00a0);
        rdChk(ZTS_OFF_UP_REL, 16'h0008);
        $display("release mirror test done");
    endtask

    task automatic pulse(input zts_trk_t t, input logic unm, input logic rev);
        @(posedge mclk);
        discharge <= 1'b1;
        dischargeTrk <= t;
        unmanagedDis <= unm;
        reverseDir <= rev;
        @(posedge mclk);
        discharge <= 1'b0;
        dischargeTrk <= ~t;
        step(2);
    endtask

    task automatic testHandoff;
        pulse('{word1: 16'h1111, word2: 16'h2222}, 1'b1, 1'b0);
        rdChk(ZTS_OFF_FWD_TRK1, 16'h1111);
        rdChk(ZTS_OFF_FWD_TRK2, 16'h2222);
        rdChk(ZTS_OFF_REV_TRK1, 16'h0000);
        pulse('{word1: 16'h3333, word2: 16'h4444}, 1'b1, 1'b1);
        rdChk(ZTS_OFF_REV_TRK1, 16'h3333);
        rdChk(ZTS_OFF_REV_TRK2, 16'h4444);
        rdChk(ZTS_OFF_FWD_TRK1, 16'h1111);
        pulse('{word1: 16'h5555, word2: 16'h6666}, 1'b0, 1'b0);
        pulse('{word1: 16'h7777, word2: 16'h8888}, 1'b0, 1'b1);
        rdChk(ZTS_OFF_FWD_TRK2, 16'h2222);
        rdChk(ZTS_OFF_REV_TRK2, 16'h4444);
        $display("hand-off tracking test done");
    endtask

    task automatic testSensor;
        @(posedge mclk);
        sensorRaw <= 4'b0101;
        step(2);
        sensChk(16'h0011);
        @(posedge mclk);
        autoCfgDone <= 1'b1;
        autoCfgInvert <= 4'b0011;
        @(posedge mclk);
        autoCfgDone <= 1'b0;
        autoCfgInvert <= 4'b0000;
        step(2);
        sensChk(16'h0014);
        @(posedge mclk);
        sensorRaw <= 4'b1000;
        autoCfgDone <= 1'b1;
        autoCfgInvert <= 4'b1111;
        @(posedge mclk);
        autoCfgDone <= 1'b0;
        step(2);
        sensChk(16'h0045);
        $display("sensor port test done");
    endtask

    task automatic testHeart;
        int ones;
        ones = 0;
        plc.rdRun(ZTS_OFF_SENSOR, 32);
        for (int i = 0; i < 32; i++) begin
            ones += plc.burst[i][15];
        end
        chkWord(zts_word_t'(ones), 16'h0010);
        for (int i = 0; i < 24; i++) begin
            chkFlag(plc.burst[i][15] ^ plc.burst[i+8][15], 1'b1);
        end
        $display("heartbeat test done");
    endtask

    task automatic testStop;
        int pos [4];
        pos = '{5, 6, 7, 10};
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            stopCause <= zts_stop_t'(4'b0001 << i);
            step(2);
            rdChk(ZTS_OFF_LINE_STOP, 16'h0001 << pos[i]);
        end
        @(posedge mclk);
        stopCause <= 4'b1111;
        step(2);
        rdChk(ZTS_OFF_LINE_STOP, 16'h04e0);
        $display("line stop test done");
    endtask

    task automatic testWrite;
        zts_word_t d;
        logic v;
        logic m;
        logic ack;
        @(posedge mclk);
        resetProtWord <= 16'hc3a5;
        plc.wr(ZTS_OFF_LINE_STOP, 16'hffff, ack);
        chkFlag(ack, 1'b1);
        plc.wr(ZTS_OFF_SENSOR, 16'hffff, ack);
        plc.wr(ZTS_OFF_RESET_PROT, 16'h0000, ack);
        rdChk(ZTS_OFF_LINE_STOP, 16'h04e0);
        sensChk(16'h0045);
        rdChk(ZTS_OFF_RESET_PROT, 16'hc3a5);
        plc.rd(8'h00, d, v, m);
        chkWord(d, 16'h0000);
        chkFlag(m, 1'b1);
        $display("write and reserved test done");
    endtask

    task automatic testDone;
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        failCount = 0;
        checks = 0;
        rst_b = 1'b0;
        {upAccum, dnAccum, discharge, unmanagedDis, reverseDir} = '0;
        {upTrk, dnTrk, dischargeTrk} = '0;
        {sensorRaw, autoCfgDone, autoCfgInvert} = '0;
        stopCause = '0;
        resetProtWord = '0;
        step(10);
        rst_b <= 1'b1;
        testCarton;
        testRelease;
        testHandoff;
        testSensor;
        testHeart;
        testStop;
        testWrite;
        testDone;
    end

    // whole run needs well under 1000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        failCount++;
        testDone;
    end
endmodule

`default_nettype wire
